// ---- common/sser_map.vh ----
`ifndef SSER_MAP_VH
`define SSER_MAP_VH

// ==========================================================
// status byte bit positions
`define SSER_SSB_TIMEOUT_BIT 0
`define SSER_SSB_BUSERR_BIT 1
`define SSER_SSB_MSGAV_BIT 4
`define SSER_SSB_EVSUM_BIT 5
`define SSER_SSB_MSS_BIT 6

// ==========================================================
// standard event status bit positions
`define SSER_EVR_OPC_BIT 0
`define SSER_EVR_ALARM_BIT 3
`define SSER_EVR_EXE_BIT 4
`define SSER_EVR_CME_BIT 5
`define SSER_EVR_PON_BIT 7

// ==========================================================
// implemented bits and power-on values
`define SSER_SSB_USED 8'h33
`define SSER_EVR_USED 8'hb9
`define SSER_EVR_RESET 8'h80
`define SSER_MASK_RESET 8'h00

// ==========================================================
// query source codes carried with each response
`define SSER_SRC_NONE 3'h0
`define SSER_SRC_SSB 3'h1
`define SSER_SRC_SRE 3'h2
`define SSER_SRC_EVR 3'h3
`define SSER_SRC_EVM 3'h4
`define SSER_SRC_POLL 3'h5

`endif

// ---- design/sser_bcd.v ----
// ==========================================================
// byte to three decimal digits, shift-and-add-three
module sser_bcd (
  input wire [7:0] i_bin,
  output reg [11:0] o_bcd
);

  integer i;
  reg [19:0] work;

  // eight unrolled passes; purely combinational, small enough for one cycle
  always @* begin
    work = {12'h000, i_bin};
    for (i = 0; i < 8; i = i + 1) begin
      if (work[11:8] > 4'h4) begin
        work[11:8] = work[11:8] + 4'h3;
      end
      if (work[15:12] > 4'h4) begin
        work[15:12] = work[15:12] + 4'h3;
      end
      if (work[19:16] > 4'h4) begin
        work[19:16] = work[19:16] + 4'h3;
      end
      work = {work[18:0], 1'b0};
    end
    o_bcd = work[19:8];
  end

endmodule

// ---- design/sser_top.v ----
`include "sser_map.vh"

module sser_top (
  input wire i_sys_clk,
  input wire i_reset,
  // common commands from the parser, one-cycle strobes
  input wire i_sre_wr,
  input wire i_evm_wr,
  input wire [7:0] i_wr_value,
  input wire i_ssb_qry,
  input wire i_sre_qry,
  input wire i_evr_qry,
  input wire i_evm_qry,
  input wire i_cls,
  input wire i_spoll_rd,
  // event sources, one-cycle strobes from same-clock logic
  input wire i_cmd_err,
  input wire i_exec_err,
  input wire i_alarm_event,
  input wire i_op_complete,
  input wire i_local_bus_error,
  input wire i_local_bus_timeout,
  // output queue level
  input wire i_outq_not_empty,
  // query answer
  output reg o_resp_valid,
  output reg [2:0] o_resp_src,
  output reg [7:0] o_resp_byte,
  output reg [11:0] o_resp_dec,
  // service request line level
  output reg o_srq
);

  // ==========================================================
  // state
  reg [7:0] sre_ff;
  reg [7:0] evm_ff;
  reg [7:0] evr_ff;
  reg lberr_ff;
  reg ltmo_ff;
  reg rqs_ff;
  reg mss_prev_ff;
  reg [7:0] nxt_sre;
  reg [7:0] nxt_evm;
  reg [7:0] nxt_evr;
  reg nxt_lberr;
  reg nxt_ltmo;
  reg nxt_rqs;

  wire esb;
  wire mav;
  wire mss;
  wire [7:0] ssb_low;
  wire [7:0] ssb_qry_val;
  wire [7:0] ssb_poll_val;
  wire [7:0] evr_set;
  reg [7:0] resp_sel;
  reg [2:0] src_sel;
  wire [11:0] resp_dec_c;

  // ==========================================================
  // summaries, combinational so reads are always consistent
  assign esb = |(evr_ff & evm_ff);
  assign mav = i_outq_not_empty;
  assign ssb_low = (8'h00 | ({7'h00, esb} << `SSER_SSB_EVSUM_BIT)
    | ({7'h00, mav} << `SSER_SSB_MSGAV_BIT)
    | ({7'h00, lberr_ff} << `SSER_SSB_BUSERR_BIT)
    | ({7'h00, ltmo_ff} << `SSER_SSB_TIMEOUT_BIT))
    & `SSER_SSB_USED;
  // bit 6 is left out of its own term to avoid a loop
  assign mss = |(ssb_low & sre_ff & 8'hbf);
  assign ssb_qry_val = ssb_low | ({7'h00, mss} << `SSER_SSB_MSS_BIT);
  assign ssb_poll_val = ssb_low
    | ({7'h00, rqs_ff} << `SSER_SSB_MSS_BIT);

  // ==========================================================
  // event strobes to register positions
  assign evr_set = (({7'h00, i_cmd_err} << `SSER_EVR_CME_BIT)
    | ({7'h00, i_exec_err} << `SSER_EVR_EXE_BIT)
    | ({7'h00, i_alarm_event} << `SSER_EVR_ALARM_BIT)
    | ({7'h00, i_op_complete} << `SSER_EVR_OPC_BIT))
    & `SSER_EVR_USED;

  // ==========================================================
  // next-state logic; a new event beats a same-cycle clear
  always @* begin
    nxt_sre = sre_ff;
    nxt_evm = evm_ff;
    nxt_evr = evr_ff;
    nxt_lberr = lberr_ff;
    nxt_ltmo = ltmo_ff;
    nxt_rqs = rqs_ff;
    // masks only change on their own set commands
    if (i_sre_wr) begin
      nxt_sre = i_wr_value;
    end
    if (i_evm_wr) begin
      nxt_evm = i_wr_value;
    end
    // no write path exists for the event register
    if (i_evr_qry || i_cls) begin
      nxt_evr = 8'h00;
    end
    nxt_evr = (nxt_evr | evr_set) & `SSER_EVR_USED;
    if (i_cls) begin
      nxt_lberr = 1'b0;
      nxt_ltmo = 1'b0;
      nxt_rqs = 1'b0;
    end
    if (i_local_bus_error) begin
      nxt_lberr = 1'b1;
    end
    if (i_local_bus_timeout) begin
      nxt_ltmo = 1'b1;
    end
    // request-service: clear on poll read or summary low
    if (i_spoll_rd || !mss) begin
      nxt_rqs = 1'b0;
    end
    // rising edge of summary sets, winning over the poll clear
    if (mss && !mss_prev_ff) begin
      nxt_rqs = 1'b1;
    end
  end

  // ==========================================================
  // registers; reset stands for power-on
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      sre_ff <= `SSER_MASK_RESET;
      evm_ff <= `SSER_MASK_RESET;
      evr_ff <= `SSER_EVR_RESET;
      lberr_ff <= 1'b0;
      ltmo_ff <= 1'b0;
      rqs_ff <= 1'b0;
      mss_prev_ff <= 1'b0;
    end else begin
      sre_ff <= nxt_sre;
      evm_ff <= nxt_evm;
      evr_ff <= nxt_evr;
      lberr_ff <= nxt_lberr;
      ltmo_ff <= nxt_ltmo;
      rqs_ff <= nxt_rqs;
      mss_prev_ff <= mss;
    end
  end

  // ==========================================================
  // answer select; parser issues one query at a time, fixed
  // priority only guards against a misbehaving parser
  always @* begin
    resp_sel = 8'h00;
    src_sel = `SSER_SRC_NONE;
    if (i_spoll_rd) begin
      resp_sel = ssb_poll_val;
      src_sel = `SSER_SRC_POLL;
    end else if (i_ssb_qry) begin
      resp_sel = ssb_qry_val;
      src_sel = `SSER_SRC_SSB;
    end else if (i_evr_qry) begin
      resp_sel = evr_ff;
      src_sel = `SSER_SRC_EVR;
    end else if (i_sre_qry) begin
      resp_sel = sre_ff;
      src_sel = `SSER_SRC_SRE;
    end else if (i_evm_qry) begin
      resp_sel = evm_ff;
      src_sel = `SSER_SRC_EVM;
    end
  end

  // decimal form of the answer for the text response
  sser_bcd u_bcd (
    .i_bin(resp_sel),
    .o_bcd(resp_dec_c)
  );

  // ==========================================================
  // registered answer, held until the next query
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_resp_valid <= 1'b0;
      o_resp_src <= `SSER_SRC_NONE;
      o_resp_byte <= 8'h00;
      o_resp_dec <= 12'h000;
      o_srq <= 1'b0;
    end else begin
      o_resp_valid <= (src_sel != `SSER_SRC_NONE);
      if (src_sel != `SSER_SRC_NONE) begin
        o_resp_src <= src_sel;
        o_resp_byte <= resp_sel;
        o_resp_dec <= resp_dec_c;
      end
      // line loads nxt_rqs on the same edge as the request-service bit, so it matches rqs_ff
      o_srq <= nxt_rqs;
    end
  end

endmodule

// ---- verif/sser_ctrl_model.sv ----
// ==========================================================
// remote controller: one strobe per common command
module sser_ctrl_model (
  input wire i_sys_clk,
  output logic [7:0] o_cmd,
  output logic [7:0] o_value
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_cmd = 8'h00;
    o_value = 8'h00;
  end
  // no command code writes the event register
  task send(input int k, input logic [7:0] v);
    @(posedge i_sys_clk);
    o_cmd <= 8'h01 << k;
    o_value <= v;
    @(posedge i_sys_clk);
    o_cmd <= 8'h00;
    o_value <= ~v; // stale value must not be relied on
  endtask
endmodule

// ---- verif/sser_properties.sv ----
// ==========================================================
// answer timing and layout, seen at the ports only
module sser_properties (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_ssb_qry,
  input wire i_sre_qry,
  input wire i_evr_qry,
  input wire i_evm_qry,
  input wire i_spoll_rd,
  input wire o_resp_valid,
  input wire [2:0] o_resp_src,
  input wire [7:0] o_resp_byte,
  input wire o_srq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // any query strobe
  wire q = i_ssb_qry | i_sre_qry | i_evr_qry | i_evm_qry | i_spoll_rd;
  sequence s_q; q; endsequence
  sequence s_ans; o_resp_valid; endsequence
  AST_ANS: assert property (s_q |=> s_ans)
    else $error("query not answered");
  AST_NOANS: assert property (!q |=> !o_resp_valid)
    else $error("answer without query");
  AST_HOLD: assert property (!q |=> $stable(o_resp_byte))
    else $error("answer byte moved");
  AST_POLL: assert property (i_spoll_rd |=> o_resp_src == 3'h5)
    else $error("poll lost priority");
  AST_SSB: assert property (i_ssb_qry && !i_spoll_rd |=>
    o_resp_src == 3'h1)
    else $error("status query source");
  AST_SSB0: assert property (o_resp_valid && o_resp_src == 3'h1 |->
    (o_resp_byte & 8'h8c) == 8'h00)
    else $error("unused status bit set");
  AST_EVR0: assert property (o_resp_valid && o_resp_src == 3'h3 |->
    (o_resp_byte & 8'h46) == 8'h00)
    else $error("unused event bit set");
  AST_RST: assert property ($fell(i_reset) |-> !o_srq && !o_resp_valid)
    else $error("outputs not clear after reset");
endmodule

bind sser_top sser_properties u_props (.i_sys_clk(i_sys_clk),
  .i_reset(i_reset), .i_ssb_qry(i_ssb_qry), .i_sre_qry(i_sre_qry),
  .i_evr_qry(i_evr_qry), .i_evm_qry(i_evm_qry), .i_spoll_rd(i_spoll_rd),
  .o_resp_valid(o_resp_valid), .o_resp_src(o_resp_src),
  .o_resp_byte(o_resp_byte), .o_srq(o_srq));

// ---- verif/sser_top_tb_top.sv ----
module sser_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [5:0] evs = 6'h00;
  logic outq = 1'b0;
  wire [7:0] cmd, val, o_resp_byte;
  wire o_resp_valid, o_srq;
  wire [2:0] o_resp_src;
  wire [11:0] o_resp_dec;
  int errors = 0, n_compared = 0, cyc = 0;
  int sre, evm, evr, lb;
  always #10 i_sys_clk = ~i_sys_clk;
  sser_ctrl_model m (.i_sys_clk(i_sys_clk), .o_cmd(cmd), .o_value(val));
  sser_top dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_sre_wr(cmd[0]), .i_evm_wr(cmd[1]), .i_wr_value(val),
    .i_ssb_qry(cmd[2]), .i_sre_qry(cmd[3]), .i_evr_qry(cmd[4]),
    .i_evm_qry(cmd[5]), .i_cls(cmd[6]), .i_spoll_rd(cmd[7]),
    .i_cmd_err(evs[0]), .i_exec_err(evs[1]), .i_alarm_event(evs[2]),
    .i_op_complete(evs[3]), .i_local_bus_error(evs[4]),
    .i_local_bus_timeout(evs[5]), .i_outq_not_empty(outq),
    .o_resp_valid(o_resp_valid), .o_resp_src(o_resp_src),
    .o_resp_byte(o_resp_byte), .o_resp_dec(o_resp_dec), .o_srq(o_srq));
  task chk(input string n, input logic [11:0] s, input logic [11:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // answer is checked 1 ns after the edge that takes the strobe
  task q(input int k, input int e);
    m.send(k, 8'h00);
    #1;
    chk("valid", o_resp_valid, 1);
    chk("src", o_resp_src, (k == 7) ? 5 : k - 1);
    chk("byte", o_resp_byte, e);
    chk("dec", o_resp_dec, e / 100 * 256 + e / 10 % 10 * 16 + e % 10);
  endtask
  // reference status byte, bit 6 kept out of its own term
  function automatic int sb();
    int s;
    s = outq * 16 + lb + (((evr & evm) != 0) ? 32 : 0);
    return s + (((s & sre & 8'hbf) != 0) ? 64 : 0);
  endfunction
  task ev(input logic [5:0] e, input logic o);
    @(posedge i_sys_clk);
    evs <= e;
    outq <= o;
    @(posedge i_sys_clk);
    evs <= 6'h00;
    evr = evr | e[0] * 32 | e[1] * 16 | e[2] * 8 | e[3];
    lb = lb | e[4] * 2 | e[5];
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(62));
    repeat (12) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    sre = 0;
    evm = 0;
    evr = 128;
    lb = 0;
    q(3, 0);
    q(5, 0);
    q(4, 128);
    evr = 0;
    q(4, 0);
    m.send(0, 8'h10);
    sre = 16;
    ev(6'h00, 1'b1);
    repeat (2) @(posedge i_sys_clk);
    #1 chk("srq", o_srq, 1);
    q(7, 80);
    repeat (2) @(posedge i_sys_clk);
    #1 chk("srq", o_srq, 0);
    ev(6'h00, 1'b0);
    for (int i = 0; i < 12; i++) begin
      sre = $urandom & 255;
      evm = $urandom & 255;
      m.send(0, 8'(sre));
      m.send(1, 8'(evm));
      q(3, sre);
      q(5, evm);
      ev(6'($urandom), 1'($urandom));
      q(2, sb());
      q(4, evr);
      evr = 0;
      if (i % 3 == 0) begin
        m.send(6, 8'h00);
        lb = 0;
        q(2, sb());
      end
    end
    final_report();
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc > 3000) begin
      errors++;
      final_report();
    end
  end
  task final_report();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
endmodule
